/* File: rtl/amb_top.sv */
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module amb_top import amb_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor side
  input wire logic cpu_valid,
  input wire logic [15:0] cpu_vaddr,
  output logic cpu_out_valid,
  output logic [21:0] cpu_paddr,
  output logic [17:0] cpu_bus_addr,
  output logic [1:0] cpu_target,
  output logic cpu_abort,
  output logic [15:0] cpu_vector,
  // DMA side
  input wire logic dma_valid,
  input wire logic [17:0] dma_addr,
  output logic dma_out_valid,
  output logic [21:0] dma_paddr,
  output logic [1:0] dma_target
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Classify a physical address
  function automatic logic [1:0] decode_target(input logic [21:0] pa, input logic [21:0] bound);
    if (pa[21:18] == BUS_PREFIX) begin
      decode_target = (pa[17:13] == IO_PAGE_SEL) ? TGT_DEVPAGE : TGT_BUS;
    end else if (pa > bound) begin
      decode_target = TGT_NXM;
    end else begin
      decode_target = TGT_MAIN;
    end
  endfunction

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  amb_state_t st;
  amb_state_t next_st;

  logic [2:0] page_sel;
  logic [6:0] block_num;
  logic [5:0] block_off;
  logic [15:0] page_base;
  logic [21:0] cpu_pa_c;
  logic [17:0] pa18;
  logic [21:0] map_sel;
  logic [21:0] dma_pa_c;
  logic do_write;
  logic [AXI_AW-1:0] wofs;
  logic [AXI_AW-1:0] rofs;
  logic [4:0] widx;
  logic [4:0] ridx;
  logic wmap_hit;
  logic rmap_hit;
  logic [31:0] rd_c;
  logic rd_ok;
  logic wr_ok;

  // ---------------------------------------------------------------
  // Processor address translation
  // ---------------------------------------------------------------
  // Split the virtual address
  assign page_sel = cpu_vaddr[15:13];
  assign block_num = cpu_vaddr[12:6];
  assign block_off = cpu_vaddr[5:0];
  assign page_base = st.par[page_sel];

  // Form the physical address per mode
  always_comb begin
    pa18 = {page_base[11:0], 6'h00} + {5'h00, block_num, block_off};
    if (!st.enable) begin
      if (page_sel == TOP_PAGE) begin
        cpu_pa_c = {BUS_PREFIX, IO_PAGE_SEL, cpu_vaddr[12:0]};
      end else begin
        cpu_pa_c = {6'h00, cpu_vaddr};
      end
    end else if (st.mode22) begin
      cpu_pa_c = {page_base + {9'h000, block_num}, block_off};
    end else if (pa18[17:13] == IO_PAGE_SEL) begin
      cpu_pa_c = {BUS_PREFIX, pa18};
    end else begin
      cpu_pa_c = {4'h0, pa18};
    end
  end

  // ---------------------------------------------------------------
  // DMA bus map
  // ---------------------------------------------------------------
  assign map_sel = (dma_addr[17:13] == IO_PAGE_SEL) ? 22'h000000 : st.map[dma_addr[17:13]];

  // Relocate or pass the DMA address; map off passes every address, I/O page too
  always_comb begin
    if (!st.map_on) begin
      dma_pa_c = {4'h0, dma_addr};
    end else if (dma_addr[17:13] == IO_PAGE_SEL) begin
      dma_pa_c = {BUS_PREFIX, dma_addr};
    end else begin
      dma_pa_c = map_sel + {9'h000, dma_addr[12:0]};
    end
  end

  // ---------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------
  assign wofs = st.awaddr;
  assign rofs = s_axi_araddr;
  assign widx = 5'((wofs - REG_MAP_BASE) >> 2);
  assign ridx = 5'((rofs - REG_MAP_BASE) >> 2);
  assign do_write = st.aw_got && st.w_got && !st.bvalid;

  // Read mux
  always_comb begin
    rd_c = 32'h00000000;
    rd_ok = 1'b1;
    if (rofs == REG_STATUS) begin
      rd_c[STS_EN_BIT] = st.enable;
    end else if (rofs == REG_CONTROL) begin
      rd_c[CTL_MODE22_BIT] = st.mode22;
      rd_c[CTL_MAP_BIT] = st.map_on;
    end else if (rofs == REG_BOUNDARY) begin
      rd_c = {10'h000, st.boundary};
    end else if (rofs == REG_RESULT) begin
      rd_c = {26'h0000000, st.dma_tgt, st.cpu_tgt, st.cpu_abort, st.cpu_ov};
    end else if (rofs >= REG_PAR_BASE && rofs < REG_PAR_BASE + 12'(NUM_PAR * 4) && rofs[1:0] == 2'b00) begin
      rd_c = {16'h0000, st.par[3'((rofs - REG_PAR_BASE) >> 2)]};
    end else if (rmap_hit) begin
      rd_c = {10'h000, st.map[ridx]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Map window checked on the full offset, so high offsets do not alias
  assign wmap_hit = wofs >= REG_MAP_BASE && wofs < REG_MAP_BASE + 12'(NUM_MAP * 4) && wofs[1:0] == 2'b00;
  assign rmap_hit = rofs >= REG_MAP_BASE && rofs < REG_MAP_BASE + 12'(NUM_MAP * 4) && rofs[1:0] == 2'b00;
  assign wr_ok = (wofs == REG_STATUS) || (wofs == REG_CONTROL) || (wofs == REG_BOUNDARY) || (wofs == REG_RESULT)
    || (wofs >= REG_PAR_BASE && wofs < REG_PAR_BASE + 12'(NUM_PAR * 4) && wofs[1:0] == 2'b00)
    || wmap_hit;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Write address and data captured in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    // Register write with byte lanes
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wofs == REG_STATUS && st.wstrb[0]) begin
        next_st.enable = st.wdata[STS_EN_BIT];
      end
      if (wofs == REG_CONTROL && st.wstrb[0]) begin
        next_st.mode22 = st.wdata[CTL_MODE22_BIT];
        next_st.map_on = st.wdata[CTL_MAP_BIT];
      end
      if (wofs == REG_BOUNDARY) begin
        next_st.boundary = 22'(merge({10'h000, st.boundary}, st.wdata, st.wstrb));
      end
      if (wofs >= REG_PAR_BASE && wofs < REG_PAR_BASE + 12'(NUM_PAR * 4) && wofs[1:0] == 2'b00) begin
        next_st.par[3'((wofs - REG_PAR_BASE) >> 2)] =
          16'(merge({16'h0000, st.par[3'((wofs - REG_PAR_BASE) >> 2)]}, st.wdata, st.wstrb));
      end
      if (wmap_hit) begin
        next_st.map[widx] = 22'(merge({10'h000, st.map[widx]}, st.wdata, st.wstrb)) & ~22'h000001;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read answered the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_c;
      next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Processor translation result
    next_st.cpu_ov = cpu_valid;
    if (cpu_valid) begin
      next_st.cpu_pa = cpu_pa_c;
      next_st.cpu_tgt = decode_target(cpu_pa_c, st.boundary);
      next_st.cpu_abort = st.enable && (decode_target(cpu_pa_c, st.boundary) == TGT_NXM);
    end
    // DMA translation result
    next_st.dma_ov = dma_valid;
    if (dma_valid) begin
      next_st.dma_pa = dma_pa_c;
      next_st.dma_tgt = decode_target(dma_pa_c, st.boundary);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
      st.boundary <= BOUNDARY_RST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready = !st.w_got && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign cpu_out_valid = st.cpu_ov;
  assign cpu_paddr = st.cpu_pa;
  assign cpu_bus_addr = st.cpu_pa[17:0];
  assign cpu_target = st.cpu_tgt;
  assign cpu_abort = st.cpu_abort;
  assign cpu_vector = st.cpu_abort ? MMU_VECTOR : 16'h0000;
  assign dma_out_valid = st.dma_ov;
  assign dma_paddr = st.dma_pa;
  assign dma_target = st.dma_tgt;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic map_lsb_any;
  always_comb begin
    map_lsb_any = 1'b0;
    for (int i = 0; i < NUM_MAP; i++) begin
      map_lsb_any = map_lsb_any | st.map[i][0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_write_taken;
    st.aw_got && st.w_got && !st.bvalid;
  endsequence
  sequence s_resp_given;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence

  property p_bresp_follow;
    s_write_taken |=> s_resp_given;
  endproperty
  a_bresp_follow: assert property (p_bresp_follow) else $error("write response missing");

  property p_dma_devpage;
    dma_valid && st.map_on && dma_addr[17:13] == IO_PAGE_SEL |=>
      dma_paddr == {BUS_PREFIX, $past(dma_addr)} && dma_target == TGT_DEVPAGE;
  endproperty
  a_dma_devpage: assert property (p_dma_devpage) else $error("device page DMA relocated");

  property p_dma_norelo;
    dma_valid && !st.map_on |=>
      dma_paddr[21:18] == 4'h0 && dma_paddr[17:0] == $past(dma_addr);
  endproperty
  a_dma_norelo: assert property (p_dma_norelo) else $error("unmapped DMA altered");

  property p_dma_relo;
    dma_valid && st.map_on && dma_addr[17:13] != IO_PAGE_SEL |=>
      dma_paddr == $past(st.map[dma_addr[17:13]]) + {9'h000, $past(dma_addr[12:0])};
  endproperty
  a_dma_relo: assert property (p_dma_relo) else $error("mapped DMA sum wrong");

  property p_map_lsb;
    !map_lsb_any;
  endproperty
  a_map_lsb: assert property (p_map_lsb) else $error("map register bit 0 set");

  property p_cpu_low16;
    cpu_valid && !st.enable && cpu_vaddr[15:13] != TOP_PAGE |=> cpu_paddr == {6'h00, $past(cpu_vaddr)};
  endproperty
  a_cpu_low16: assert property (p_cpu_low16) else $error("16-bit low map wrong");

  property p_cpu_top16;
    cpu_valid && !st.enable && cpu_vaddr[15:13] == TOP_PAGE |=>
      cpu_target == TGT_DEVPAGE && cpu_bus_addr == {IO_PAGE_SEL, $past(cpu_vaddr[12:0])};
  endproperty
  a_cpu_top16: assert property (p_cpu_top16) else $error("16-bit top page not on bus");

  property p_bus_strip;
    cpu_out_valid && (cpu_target == TGT_BUS || cpu_target == TGT_DEVPAGE) |->
      cpu_paddr[21:18] == BUS_PREFIX && cpu_bus_addr == cpu_paddr[17:0];
  endproperty
  a_bus_strip: assert property (p_bus_strip) else $error("bus address not stripped");

  property p_nxm_vector;
    cpu_out_valid && cpu_abort |-> cpu_target == TGT_NXM && cpu_vector == MMU_VECTOR;
  endproperty
  a_nxm_vector: assert property (p_nxm_vector) else $error("abort vector wrong");

  property p_main_range;
    dma_out_valid && dma_target == TGT_MAIN |-> dma_paddr <= $past(st.boundary) && dma_paddr[21:18] != BUS_PREFIX;
  endproperty
  a_main_range: assert property (p_main_range) else $error("main decode out of range");

  property p_cpu_22bit;
    cpu_valid && st.enable && st.mode22 |=>
      cpu_paddr == {$past(st.par[cpu_vaddr[15:13]]) + {9'h000, $past(cpu_vaddr[12:6])}, $past(cpu_vaddr[5:0])};
  endproperty
  a_cpu_22bit: assert property (p_cpu_22bit) else $error("22-bit translation wrong");

  property p_cpu_18bit;
    cpu_valid && st.enable && !st.mode22 |=>
      (cpu_paddr[21:18] == 4'h0 || cpu_paddr[21:18] == BUS_PREFIX) &&
      cpu_paddr[17:0] == {$past(st.par[cpu_vaddr[15:13]][11:0]), 6'h00} + {5'h00, $past(cpu_vaddr[12:0])};
  endproperty
  a_cpu_18bit: assert property (p_cpu_18bit) else $error("18-bit relocation wrong");

  property p_decode_main;
    cpu_out_valid && cpu_paddr[21:18] != BUS_PREFIX && cpu_paddr <= $past(st.boundary) |->
      cpu_target == TGT_MAIN;
  endproperty
  a_decode_main: assert property (p_decode_main) else $error("main memory decode wrong");

  property p_decode_nxm;
    cpu_out_valid && cpu_paddr[21:18] != BUS_PREFIX && cpu_paddr > $past(st.boundary) |->
      cpu_target == TGT_NXM;
  endproperty
  a_decode_nxm: assert property (p_decode_nxm) else $error("nonexistent memory decode wrong");

  property p_decode_bus;
    cpu_out_valid && cpu_paddr[21:18] == BUS_PREFIX |->
      (cpu_target == TGT_BUS || cpu_target == TGT_DEVPAGE) &&
      ((cpu_target == TGT_DEVPAGE) == (cpu_paddr[17:13] == IO_PAGE_SEL));
  endproperty
  a_decode_bus: assert property (p_decode_bus) else $error("bus decode wrong");

  property p_abort_off;
    cpu_valid && !st.enable |=> !cpu_abort;
  endproperty
  a_abort_off: assert property (p_abort_off) else $error("abort with translation off");

  property p_vector_idle;
    !cpu_abort |-> cpu_vector == 16'h0000;
  endproperty
  a_vector_idle: assert property (p_vector_idle) else $error("vector without abort");

endmodule

/* File: shared/amb_pkg.sv */
package amb_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int AXI_AW = 12;
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_CONTROL = 12'h004;
  localparam logic [11:0] REG_BOUNDARY = 12'h008;
  localparam logic [11:0] REG_RESULT = 12'h00c;
  localparam logic [11:0] REG_PAR_BASE = 12'h020;
  localparam logic [11:0] REG_MAP_BASE = 12'h080;
  localparam int NUM_PAR = 8;
  localparam int NUM_MAP = 31;

  // ---------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------
  localparam int STS_EN_BIT = 0;
  localparam int CTL_MODE22_BIT = 4;
  localparam int CTL_MAP_BIT = 5;
  localparam logic [21:0] BOUNDARY_RST = 22'o16777777;
  localparam logic [3:0] BUS_PREFIX = 4'hf;
  localparam logic [4:0] IO_PAGE_SEL = 5'h1f;
  localparam logic [2:0] TOP_PAGE = 3'h7;
  localparam logic [15:0] MMU_VECTOR = 16'o250;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Decode targets
  localparam logic [1:0] TGT_MAIN = 2'd0;
  localparam logic [1:0] TGT_BUS = 2'd1;
  localparam logic [1:0] TGT_DEVPAGE = 2'd2;
  localparam logic [1:0] TGT_NXM = 2'd3;

  typedef struct packed {
    logic enable;
    logic mode22;
    logic map_on;
    logic [21:0] boundary;
    logic [NUM_PAR-1:0][15:0] par;
    logic [NUM_MAP-1:0][21:0] map;
    logic aw_got;
    logic [AXI_AW-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cpu_ov;
    logic [21:0] cpu_pa;
    logic [1:0] cpu_tgt;
    logic cpu_abort;
    logic dma_ov;
    logic [21:0] dma_pa;
    logic [1:0] dma_tgt;
  } amb_state_t;

endpackage

/* File: verif/address_mapping_and_bus_map_tb.sv */
`timescale 1ns/1ps
module address_mapping_and_bus_map_tb;
  import amb_pkg::*;
  logic clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, ctg, dtg;
  logic cpu_valid, dma_valid, cov, cab, dov;
  logic [15:0] cpu_vaddr, cvec;
  logic [17:0] dma_addr, cba;
  logic [21:0] cpa, dpa;
  int err_count, n_checks, cycles;

  amb_top dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_valid(cpu_valid),
    .cpu_vaddr(cpu_vaddr), .cpu_out_valid(cov), .cpu_paddr(cpa), .cpu_bus_addr(cba),
    .cpu_target(ctg), .cpu_abort(cab), .cpu_vector(cvec), .dma_valid(dma_valid),
    .dma_addr(dma_addr), .dma_out_valid(dov), .dma_paddr(dpa), .dma_target(dtg));
  amb_host_model m (.clk(clk), .cpu_valid(cpu_valid), .cpu_vaddr(cpu_vaddr),
    .dma_valid(dma_valid), .dma_addr(dma_addr));

  // ---------------------------------------------------------------
  // Clock, hang guard, compare and close
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Register bus master
  // ---------------------------------------------------------------
  task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd, ah, wh, h;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(negedge clk);
      ah = !ad && awready;
      wh = !wd && wready;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      ad = ad || ah;
      wd = wd || wh;
    end
    h = 1'b0;
    while (!h) begin
      @(negedge clk);
      h = bvalid;
      r = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
    chk("bresp", 32'(r), 32'(er));
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic h;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    h = 1'b0;
    while (!h) begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    h = 1'b0;
    while (!h) begin
      @(negedge clk);
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
    chk("rdata", d, e);
    chk("rresp", 32'(r), 32'(er));
  endtask

  // Translation requests with expected results one cycle later
  task automatic cx(input logic [15:0] va, input logic [21:0] pa, input logic [1:0] t, input logic ab);
    m.cpu_req(va, 0);
    @(negedge clk);
    chk("cpu_out_valid", 32'(cov), 32'h1);
    chk("cpu_paddr", 32'(cpa), 32'(pa));
    chk("cpu_bus_addr", 32'(cba), 32'(pa[17:0]));
    chk("cpu_target", 32'(ctg), 32'(t));
    chk("cpu_abort", 32'(cab), 32'(ab));
    chk("cpu_vector", 32'(cvec), ab ? 32'o250 : 32'h0);
  endtask
  task automatic dx(input logic [17:0] a, input logic [21:0] pa, input logic [1:0] t);
    m.dma_req(a, 2);
    @(negedge clk);
    chk("dma_out_valid", 32'(dov), 32'h1);
    chk("dma_paddr", 32'(dpa), 32'(pa));
    chk("dma_target", 32'(dtg), 32'(t));
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    err_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rchk(REG_STATUS, 32'h0, RESP_OKAY);
    rchk(REG_CONTROL, 32'h0, RESP_OKAY);
    rchk(REG_BOUNDARY, 32'o16777777, RESP_OKAY);
    wchk(12'h040, 32'h1, RESP_SLVERR);
    rchk(12'h0fc, 32'h0, RESP_SLVERR);
    wchk(12'h100, 32'h4, RESP_SLVERR);
    rchk(REG_MAP_BASE, 32'h0, RESP_OKAY);
    wchk(REG_MAP_BASE + 12'd120, 32'hffffffff, RESP_OKAY);
    rchk(REG_MAP_BASE + 12'd120, 32'h003ffffe, RESP_OKAY);
    wchk(REG_CONTROL, 32'hffffffff, RESP_OKAY);
    rchk(REG_CONTROL, 32'h00000030, RESP_OKAY);
    $display("test registers done");
    wchk(REG_CONTROL, 32'h20, RESP_OKAY);
    cx(16'o017776, 22'o00017776, TGT_MAIN, 1'b0);
    cx(16'o177776, 22'o17777776, TGT_DEVPAGE, 1'b0);
    $display("test direct mapping done");
    wchk(REG_MAP_BASE + 12'd20, 32'o01234500, RESP_OKAY);
    wchk(REG_MAP_BASE + 12'd120, 32'o16000000, RESP_OKAY);
    dx({5'd5, 13'o7776}, 22'o01234500 + 22'o7776, TGT_MAIN);
    dx({5'd30, 13'o0017}, 22'o16000017, TGT_MAIN);
    dx(18'o760010, 22'o17760010, TGT_DEVPAGE);
    wchk(REG_CONTROL, 32'h0, RESP_OKAY);
    dx(18'o760010, 22'o00760010, TGT_MAIN);
    dx(18'o127776, 22'o00127776, TGT_MAIN);
    $display("test bus map done");
    wchk(REG_PAR_BASE + 12'd4, 32'o1234, RESP_OKAY);
    wchk(REG_STATUS, 32'h1, RESP_OKAY);
    cx({3'd1, 7'd5, 6'd3}, 22'o00124103, TGT_MAIN, 1'b0);
    wchk(REG_CONTROL, 32'h10, RESP_OKAY);
    wchk(REG_PAR_BASE + 12'd8, 32'o135460, RESP_OKAY);
    wchk(REG_PAR_BASE + 12'd12, 32'o170100, RESP_OKAY);
    wchk(REG_PAR_BASE + 12'd16, 32'o177600, RESP_OKAY);
    cx({3'd2, 7'd10, 6'd7}, 22'o13547207, TGT_MAIN, 1'b0);
    cx({3'd3, 7'd1, 6'd2}, 22'o17010102, TGT_BUS, 1'b0);
    cx({3'd4, 7'd0, 6'd4}, 22'o17760004, TGT_DEVPAGE, 1'b0);
    $display("test relocation done");
    wchk(REG_BOUNDARY, 32'o00777777, RESP_OKAY);
    wchk(REG_PAR_BASE + 12'd20, 32'o007777, RESP_OKAY);
    wchk(REG_PAR_BASE + 12'd24, 32'o010000, RESP_OKAY);
    cx({3'd5, 7'd0, 6'o77}, 22'o00777777, TGT_MAIN, 1'b0);
    cx(16'o140000, 22'o01000000, TGT_NXM, 1'b1);
    cx(16'o000250, 22'o00000250, TGT_MAIN, 1'b0);
    wchk(REG_STATUS, 32'h0, RESP_OKAY);
    wchk(REG_BOUNDARY, 32'o00007777, RESP_OKAY);
    cx(16'o010000, 22'o00010000, TGT_NXM, 1'b0);
    dx(18'o020000, 22'o00020000, TGT_NXM);
    $display("test nonexistent memory done");
    test_done();
  end
endmodule

/* File: verif/amb_host_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Processor and DMA requesters on the far side of the translator
// ---------------------------------------------------------------
module amb_host_model (
  input wire logic clk,
  output logic cpu_valid,
  output logic [15:0] cpu_vaddr,
  output logic dma_valid,
  output logic [17:0] dma_addr
);
  initial begin
    cpu_valid = 1'b0;
    cpu_vaddr = 16'h0000;
    dma_valid = 1'b0;
    dma_addr = 18'h00000;
  end
  // One-cycle request after idle cycles; address inverted once dropped
  task automatic cpu_req(input logic [15:0] va, input int idle);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    cpu_valid <= 1'b1;
    cpu_vaddr <= va;
    @(posedge clk);
    cpu_valid <= 1'b0;
    cpu_vaddr <= ~va;
  endtask
  // Same for a bus device asking for memory
  task automatic dma_req(input logic [17:0] a, input int idle);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    dma_valid <= 1'b1;
    dma_addr <= a;
    @(posedge clk);
    dma_valid <= 1'b0;
    dma_addr <= ~a;
  endtask
endmodule
